/* File: xpt_loader.sv */
`timescale 1ns/1ps
module xpt_loader
	import xpt_loader_pkg::*;
#(
	parameter int OUTS  = NUM_OUTPUTS,
	parameter int WBITS = WORD_BITS
) (
	input  wire logic                      clk,
	input  wire logic                      reset,
	input  wire logic                      clk_en,
	input  wire logic                      link_clk,
	input  wire logic                      chip_select_n,
	input  wire logic                      update_n,
	input  wire logic                      reset_pin_n,
	input  wire logic                      load_mode_select,
	input  wire logic                      serial_in,
	input  wire logic [ADDR_BITS-1:0]      output_address,
	input  wire logic [WBITS-1:0]          setting_word,
	output logic                           serial_out,
	output logic      [OUTS*SEL_BITS-1:0]  input_select,
	output logic      [OUTS-1:0]           output_on,
	output logic      [OUTS*OUTS-1:0]      route_onehot
);

	logic [OUTS*WBITS-1:0] chain;
	logic [OUTS*WBITS-1:0] chain_s1_q;
	logic [OUTS*WBITS-1:0] chain_s2_q;
	logic [OUTS*WBITS-1:0] latch_q;
	logic [2:0]            ctl_s1_q;
	logic [2:0]            ctl_s2_q;
	logic                  cs_n_s;
	logic                  upd_n_s;
	logic                  rst_n_s;
	logic                  transparent;
	logic                  off_now;

	link_shifter #(
		.OUTS  (OUTS),
		.WBITS (WBITS),
		.ABITS (ADDR_BITS)
	) u_shift (
		.link_clk         (link_clk),
		.chip_select_n    (chip_select_n),
		.update_n         (update_n),
		.reset_pin_n      (reset_pin_n),
		.load_mode_select (load_mode_select),
		.serial_in        (serial_in),
		.output_address   (output_address),
		.setting_word     (setting_word),
		.chain_q          (chain),
		.serial_out       (serial_out)
	);

	// two-stage capture of pins into the core domain
	always_ff @(posedge clk) begin
		if (reset) begin
			ctl_s1_q <= 3'h7;
			ctl_s2_q <= 3'h7;
		end else if (clk_en) begin
			ctl_s1_q <= {chip_select_n, update_n, reset_pin_n};
			ctl_s2_q <= ctl_s1_q;
		end
	end

	// register contents double-captured; host keeps it still while update is low
	// no handshake here: the control bits and the word take the same two stages,
	// so by the time a low update is seen the word was captured after it settled
	// limitation: a link edge just before update falls can tear the captured word; edges while it is low are ignored
	// trade-off: a wide sampler instead of a request and acknowledge across domains
	always_ff @(posedge clk) begin
		if (reset) begin
			chain_s1_q <= CHAIN_RESET;
			chain_s2_q <= CHAIN_RESET;
		end else if (clk_en) begin
			chain_s1_q <= chain;
			chain_s2_q <= chain_s1_q;
		end
	end

	assign cs_n_s  = ctl_s2_q[2];
	assign upd_n_s = ctl_s2_q[1];
	assign rst_n_s = ctl_s2_q[0];
	assign transparent = !cs_n_s && !upd_n_s && rst_n_s;

	// switch latches: follow while transparent, hold otherwise
	always_ff @(posedge clk) begin
		if (reset) begin
			latch_q <= CHAIN_RESET;
		end else if (clk_en && transparent) begin
			latch_q <= chain_s2_q;
		end
	end

	// pin reset acts without any clock; contents of the loader stay put
	assign off_now = !reset_pin_n || reset;

	// per-output decode of select and enable
	for (genvar o = 0; o < OUTS; o++) begin : g_out
		logic [WBITS-1:0] word;
		assign word = off_now ? WORD_OFF : latch_q[o*WBITS +: WBITS];
		assign input_select[o*SEL_BITS +: SEL_BITS] = word[SEL_LSB +: SEL_BITS];
		assign output_on[o] = word[ON_BIT];
		// one-hot row, all zero when the output is off
		for (genvar i = 0; i < OUTS; i++) begin : g_in
			assign route_onehot[o*OUTS+i] = word[ON_BIT] &&
				(word[SEL_LSB +: SEL_BITS] == SEL_BITS'(i));
		end
		// each row picks at most one input, and only while the output is on
		row_onehot_a: assert property (@(posedge clk)
			$onehot0(route_onehot[o*OUTS +: OUTS]))
			else $error("output row routes several inputs");
		row_on_a: assert property (@(posedge clk)
			(|route_onehot[o*OUTS +: OUTS]) == output_on[o])
			else $error("output row and enable disagree");
		row_pick_a: assert property (@(posedge clk)
			output_on[o] |-> route_onehot[o*OUTS + input_select[o*SEL_BITS +: SEL_BITS]])
			else $error("output row misses selected input");
	end

	// checks
	sequence upd_low_s;
		!upd_n_s && !cs_n_s && rst_n_s && clk_en;
	endsequence

	latch_follow_a: assert property (@(posedge clk) disable iff (reset)
		upd_low_s |=> latch_q == $past(chain_s2_q))
		else $error("latches did not follow register");

	latch_hold_a: assert property (@(posedge clk) disable iff (reset)
		(upd_n_s || cs_n_s) |=> $stable(latch_q))
		else $error("latches changed while holding");

	pin_reset_a: assert property (@(posedge clk) disable iff (reset)
		!reset_pin_n |-> output_on == '0 && route_onehot == '0)
		else $error("outputs active during pin reset");

	pin_keep_a: assert property (@(posedge clk) disable iff (reset)
		(!rst_n_s && clk_en) |=> $stable(latch_q))
		else $error("pin reset changed latch contents");

	off_ignores_a: assert property (@(posedge clk) disable iff (reset)
		(reset_pin_n && !output_on[0]) |-> route_onehot[OUTS-1:0] == '0)
		else $error("disabled output still routed");

	onehot_a: assert property (@(posedge clk) disable iff (reset)
		output_on[0] |-> route_onehot[input_select[SEL_BITS-1:0]])
		else $error("route does not match selection");

	shift_a: assert property (@(negedge link_clk)
		(!chip_select_n && update_n && reset_pin_n && !load_mode_select)
		|=> chain[0] == $past(serial_in))
		else $error("serial bit not shifted in");

	ignore_a: assert property (@(negedge link_clk)
		chip_select_n |=> $stable(chain))
		else $error("register changed while deselected");

	par_a: assert property (@(negedge link_clk)
		(!chip_select_n && update_n && reset_pin_n && load_mode_select)
		|=> chain[$past(output_address)*WBITS +: WBITS] == $past(setting_word))
		else $error("parallel word not written");

	dout_a: assert property (@(negedge link_clk)
		(!chip_select_n && update_n && reset_pin_n && !load_mode_select)
		|=> serial_out === $past(chain[OUTS*WBITS-2]))
		else $error("serial out not last stage");

	// link-side load conditions, shared by the shift and parallel-write checks below
	sequence ser_load_s;
		!chip_select_n && update_n && reset_pin_n && !load_mode_select;
	endsequence

	sequence par_load_s;
		!chip_select_n && update_n && reset_pin_n && load_mode_select;
	endsequence

	// the whole register moves up one place per serial edge
	shift_whole_a: assert property (@(negedge link_clk)
		ser_load_s
		|=> chain[OUTS*WBITS-1:1] === $past(chain[OUTS*WBITS-2:0]))
		else $error("register did not shift as a whole");

	// a parallel write leaves the top slot alone unless it is addressed
	par_keep_top_a: assert property (@(negedge link_clk)
		(par_load_s ##0 (output_address != ADDR_BITS'(OUTS-1)))
		|=> chain[OUTS*WBITS-1 -: WBITS] === $past(chain[OUTS*WBITS-1 -: WBITS]))
		else $error("parallel write hit unaddressed top slot");

	// same for the bottom slot
	par_keep_low_a: assert property (@(negedge link_clk)
		(par_load_s ##0 (output_address != '0))
		|=> chain[WBITS-1:0] === $past(chain[WBITS-1:0]))
		else $error("parallel write hit unaddressed low slot");

	// chain output does not move when the top slot is not written
	par_dout_a: assert property (@(negedge link_clk)
		(par_load_s ##0 (output_address != ADDR_BITS'(OUTS-1)))
		|=> $stable(serial_out))
		else $error("serial out moved on parallel write");

	// this loader takes no edges while update is low
	upd_low_keep_a: assert property (@(negedge link_clk)
		!update_n |=> $stable(chain))
		else $error("register changed with update low");

	// pin reset never touches the shift register
	chain_keep_a: assert property (@(negedge link_clk)
		!reset_pin_n |=> $stable(chain))
		else $error("pin reset changed the register");

	// core-side checks: reset, clock enable, the sampler stages, latch hold and transfer, and decode
	// core reset clears the latches and darkens every output
	reset_clear_a: assert property (@(posedge clk)
		reset |=> latch_q == CHAIN_RESET)
		else $error("latches not cleared by reset");

	reset_off_a: assert property (@(posedge clk)
		reset
		|-> output_on == '0 && input_select == '0 && route_onehot == '0)
		else $error("outputs active during core reset");

	pin_sel_zero_a: assert property (@(posedge clk) disable iff (reset)
		!reset_pin_n |-> input_select == '0)
		else $error("selection shown during pin reset");

	// clock enable low freezes every core stage
	freeze_a: assert property (@(posedge clk) disable iff (reset)
		!clk_en
		|=> $stable(latch_q) && $stable(ctl_s2_q) && $stable(chain_s2_q))
		else $error("core state moved with clock enable low");

	// word sampler advances one stage per enabled edge
	sync_stage_a: assert property (@(posedge clk) disable iff (reset)
		clk_en
		|=> chain_s2_q === $past(chain_s1_q))
		else $error("word sampler skipped a stage");

	// control sampler advances one stage per enabled edge
	ctl_stage_a: assert property (@(posedge clk) disable iff (reset)
		clk_en
		|=> ctl_s2_q == $past(ctl_s1_q))
		else $error("control sampler skipped a stage");

	// holding latches keep the outputs still while the pin reset stays off
	hold_out_a: assert property (@(posedge clk) disable iff (reset)
		(upd_n_s && reset_pin_n) ##1 reset_pin_n
		|-> $stable(output_on) && $stable(input_select))
		else $error("outputs moved while latches hold");

	// a strobe seen twice over a steady word leaves that word in the latches
	sequence steady_s;
		$stable(chain_s2_q);
	endsequence

	steady_xfer_a: assert property (@(posedge clk) disable iff (reset)
		upd_low_s ##1 (upd_low_s and steady_s)
		|=> latch_q == $past(chain_s2_q, 2))
		else $error("steady word not transferred");

	// releasing the pin reset brings back the old latch contents
	pin_back_a: assert property (@(posedge clk) disable iff (reset)
		($rose(rst_n_s) && upd_n_s)
		|-> latch_q == $past(latch_q))
		else $error("latches lost contents over pin reset");

	// disabled top output routes nothing
	off_top_a: assert property (@(posedge clk) disable iff (reset)
		(reset_pin_n && !output_on[OUTS-1])
		|-> route_onehot[OUTS*OUTS-1 -: OUTS] == '0)
		else $error("disabled top output still routed");

	// a strobe with chip select high is ignored
	cs_block_a: assert property (@(posedge clk) disable iff (reset)
		(cs_n_s && !upd_n_s)
		|=> $stable(latch_q))
		else $error("latches took a deselected strobe");

endmodule

/* File: xpt_loader_pkg.sv */
package xpt_loader_pkg;

	localparam int NUM_OUTPUTS = 16;
	localparam int NUM_INPUTS  = 16;
	localparam int WORD_BITS   = 5;
	localparam int SEL_BITS    = 4;
	localparam int ADDR_BITS   = 4;
	localparam int CHAIN_BITS  = NUM_OUTPUTS * WORD_BITS;   // 80

	// field positions inside one setting word
	localparam int SEL_LSB     = 0;
	localparam int ON_BIT      = 4;

	// reset values
	localparam logic [CHAIN_BITS-1:0] CHAIN_RESET = '0;
	localparam logic [WORD_BITS-1:0]  WORD_OFF    = 5'h00;

endpackage

/* File: link_shifter.sv */
`timescale 1ns/1ps
// link-side loader: runs on the falling edge of the programming clock
module link_shifter
	import xpt_loader_pkg::*;
#(
	parameter int OUTS  = NUM_OUTPUTS,
	parameter int WBITS = WORD_BITS,
	parameter int ABITS = ADDR_BITS
) (
	input  wire logic                  link_clk,
	input  wire logic                  chip_select_n,
	input  wire logic                  update_n,
	input  wire logic                  reset_pin_n,
	input  wire logic                  load_mode_select,
	input  wire logic                  serial_in,
	input  wire logic [ABITS-1:0]      output_address,
	input  wire logic [WBITS-1:0]      setting_word,
	output logic      [OUTS*WBITS-1:0] chain_q,
	output logic                       serial_out
);

	logic load_ok;

	// loads need select low, update high and reset inactive
	assign load_ok = !chip_select_n && update_n && reset_pin_n;

	// falling edge sampling of every programming input
	always_ff @(negedge link_clk) begin
		if (load_ok) begin
			if (!load_mode_select) begin
				chain_q <= {chain_q[OUTS*WBITS-2:0], serial_in};
			end else begin
				chain_q[output_address*WBITS +: WBITS] <= setting_word;
			end
		end
	end

	// bit shifted in appears here after the whole chain length of edges
	assign serial_out = chain_q[OUTS*WBITS-1];

endmodule

/* File: prog_host.sv */
`timescale 1ns/1ps
// host model: link clock idles high and only toggles inside a transfer
module prog_host (
	output logic       link_clk,
	output logic       chip_select_n,
	output logic       update_n,
	output logic       load_mode_select,
	output logic       serial_in,
	output logic [3:0] output_address,
	output logic [4:0] setting_word
);
	// pins start defined, select low, update held high
	initial begin
		link_clk = 1'b1;
		chip_select_n = 1'b0;
		update_n = 1'b1;
		{load_mode_select, serial_in, output_address, setting_word} = '0;
	end
	// one falling edge, data valid around it, then lines scrambled
	task automatic fall(input logic m, input logic b, input logic [3:0] a, input logic [4:0] w);
		load_mode_select = m;
		serial_in = b;
		output_address = a;
		setting_word = w;
		#15 link_clk = 1'b0;
		#15 link_clk = 1'b1;
		serial_in = ~b;
		setting_word = ~w;
	endtask
	// chip select only moves between transfers
	task automatic set_cs_n(input logic v);
		chip_select_n = v;
	endtask
	// strobe only after the whole load, long enough for the core sampler
	task automatic strobe();
		update_n = 1'b0;
		#600 update_n = 1'b1;
	endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import xpt_loader_pkg::*;
	logic clk, reset, clk_en, reset_pin_n, lc, cs_n, up_n, md, si, so;
	logic [3:0] ad;
	logic [4:0] wd, nw;
	logic [63:0] sel;
	logic [15:0] on;
	logic [255:0] rt;
	logic [79:0] sh, lat;
	int miscompares, num_checks, seed, a;
	prog_host h (.link_clk(lc), .chip_select_n(cs_n), .update_n(up_n),
		.load_mode_select(md), .serial_in(si), .output_address(ad), .setting_word(wd));
	xpt_loader i_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .link_clk(lc),
		.chip_select_n(cs_n), .update_n(up_n), .reset_pin_n(reset_pin_n),
		.load_mode_select(md), .serial_in(si), .output_address(ad), .setting_word(wd),
		.serial_out(so), .input_select(sel), .output_on(on), .route_onehot(rt));
	task automatic cmp(string n, logic [255:0] e, logic [255:0] g);
		num_checks++;
		if (e !== g) begin
			$display("Error %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask
	// expected outputs from a latched image; en low models the reset pin
	task automatic chk(logic [79:0] v, logic en);
		logic [63:0] s;
		logic [15:0] e;
		logic [255:0] r;
		s = '0;
		e = '0;
		r = '0;
		for (int o = 0; o < 16; o++) begin
			e[o] = en & v[5*o+4];
			if (en) s[4*o+:4] = v[5*o+:4];
			if (e[o]) r[16*o+v[5*o+:4]] = 1'b1;
		end
		cmp("input_select", s, sel);
		cmp("output_on", e, on);
		cmp("route_onehot", r, rt);
	endtask
	task automatic wrap_up();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// watchdog, run needs well under 100 us
	initial begin
		#200000 miscompares++;
		wrap_up();
	end
	initial begin
		seed = 32'ha957;
		{reset, clk_en, reset_pin_n} = 3'b111;
		repeat (6) @(posedge clk);
		#5 reset = 1'b0;
		// two full serial loads, second one watches the chain output
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 80; i++) begin
				sh = {sh[78:0], 1'($random(seed))};
				h.fall(1'b0, sh[0], 4'h0, 5'h00);
				if (p == 1) cmp("serial_out", sh[79], so);
			end
		end
		h.strobe();
		lat = sh;
		chk(lat, 1'b1);
		// shifting behind a high update must not reach the matrix
		for (int i = 0; i < 5; i++) begin
			sh = {sh[78:0], 1'($random(seed))};
			h.fall(1'b0, sh[0], 4'h0, 5'h00);
		end
		chk(lat, 1'b1);
		// deselected: edges and strobe are ignored
		h.set_cs_n(1'b1);
		h.fall(1'b0, 1'b1, 4'h0, 5'h00);
		h.strobe();
		h.set_cs_n(1'b0);
		chk(lat, 1'b1);
		// parallel words, both end addresses first
		for (int k = 0; k < 8; k++) begin
			a = (k == 0) ? 0 : (k == 1) ? 15 : ($random(seed) & 15);
			nw = 5'($random(seed));
			sh[5*a+:5] = nw;
			h.fall(1'b1, 1'b0, 4'(a), nw);
		end
		h.strobe();
		lat = sh;
		chk(lat, 1'b1);
		// reset pin disables outputs at once, content survives
		#5 reset_pin_n = 1'b0;
		h.fall(1'b0, 1'b1, 4'h0, 5'h00);
		chk(lat, 1'b0);
		reset_pin_n = 1'b1;
		repeat (5) @(posedge clk);
		#5 chk(lat, 1'b1);
		// frozen core must not take a strobe, then a live one lands it
		nw = 5'($random(seed)) | 5'h10;
		sh[0+:5] = nw;
		h.fall(1'b1, 1'b0, 4'h0, nw);
		@(posedge clk);
		#5 clk_en = 1'b0;
		h.strobe();
		@(posedge clk);
		#5 clk_en = 1'b1;
		chk(lat, 1'b1);
		h.strobe();
		lat = sh;
		chk(lat, 1'b1);
		// core reset mid-run darkens outputs and clears the latches
		@(posedge clk);
		#5 reset = 1'b1;
		repeat (2) @(posedge clk);
		#5 chk(lat, 1'b0);
		reset = 1'b0;
		repeat (2) @(posedge clk);
		#5 chk(CHAIN_RESET, 1'b1);
		wrap_up();
	end
endmodule
